// ### src/aps_pkg.sv
// Purpose: Types shared by the analog pin select block.
// Assumes: Nothing beyond the header.
// Notes:   Reference sources are coded for the converter front end.
package aps_pkg;
	// ======================================================
	// Variant of the select word
	typedef enum logic [1:0] {
		APS_VAR_SEQ = 2'h0,
		APS_VAR_MASK = 2'h1,
		APS_VAR_PIN = 2'h3
	} aps_variant_type;
	// ======================================================
	// Positive reference source
	typedef enum logic [1:0] {
		APS_REFP_SUPPLY = 2'h0,
		APS_REFP_PIN = 2'h1,
		APS_REFP_FIXED = 2'h2
	} aps_refp_type;
	// ======================================================
	// Negative reference source
	typedef enum logic [0:0] {
		APS_REFN_GROUND = 1'h0,
		APS_REFN_PIN = 1'h1
	} aps_refn_type;
endpackage

// ### src/aps_regs.svh
// Purpose: Register offsets, field positions and reset values for the
//          analog pin select block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef APS_REGS_SVH
`define APS_REGS_SVH
// ==========================================================
// Offsets
`define APS_SELECT_OFFSET 12'h000
`define APS_CONFIG_OFFSET 12'h004
`define APS_STATUS_OFFSET 12'h008
`define APS_REFCFG_OFFSET 12'h00c
// ==========================================================
// Fields
`define APS_REFP_BIT 14
`define APS_REFN_BIT 15
`define APS_SEQ_REFN_CH 2
`define APS_SEQ_REFP_CH 3
`define APS_SMALL_REFP_CH 1
`define APS_SEQ_BASE_CH 4
// ==========================================================
// Reset values
`define APS_SELECT_RESET 16'h0000
`define APS_CONFIG_RESET 3'h0
`define APS_REFCFG_RESET 4'h0
`endif

// ### src/aps_select.sv
// Purpose: APB analog pin select register and its decode to buffers and refs.
// Assumes: One clock; inputs synchronous to pclk.
// Notes:   Variant and part size come from a config register.
`timescale 1ns/100ps
`default_nettype none
`include "aps_regs.svh"
module aps_select
	import aps_pkg::*;
#(
	parameter int PINS = 16
)
(
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pin state
	input wire logic [PINS-1:0] pin_analog_cap,
	input wire logic [PINS-1:0] pin_is_input,
	// Automatic set from analog read or touch
	input wire logic use_valid,
	input wire logic [3:0] use_pin,
	// Converter side
	output logic [PINS-1:0] dig_buf_off,
	output aps_refp_type refp_sel,
	output aps_refn_type refn_sel,
	output logic [3:0] refp_chan,
	output logic [3:0] refn_chan
);
	// ======================================================
	// Registers
	logic [15:0] select_reg;
	logic [15:0] select_next;
	logic [2:0] config_reg;
	logic [3:0] refcfg_reg;
	aps_variant_type variant;
	logic large_part;
	logic small_part;
	logic wr_en;
	logic rd_hit;
	logic [15:0] seq_mask;
	logic [15:0] mask_eff;
	logic [15:0] pin_valid;
	logic [15:0] set_mask;
	assign variant = aps_variant_type'(config_reg[1:0]);
	assign large_part = config_reg[2];
	assign small_part = ~config_reg[2];
	assign wr_en = psel & penable & pwrite;
	assign pready = 1'b1;
	// ======================================================
	// Address decode
	function automatic logic known_addr(input logic [11:0] a);
		known_addr = (a == `APS_SELECT_OFFSET) || (a == `APS_CONFIG_OFFSET)
			|| (a == `APS_STATUS_OFFSET) || (a == `APS_REFCFG_OFFSET);
	endfunction
	assign pslverr = psel & penable & ~known_addr(paddr);
	assign rd_hit = psel & ~penable & ~pwrite;
	// Merge bytes of a write into a word
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction
	// ======================================================
	// Per-pin bits that exist on this part
	always_comb
	begin
		if (variant == APS_VAR_PIN && small_part)
			pin_valid = 16'h0016;
		else
			pin_valid = 16'hffff;
		set_mask = 16'h0000;
		if (use_valid && variant == APS_VAR_PIN)
			set_mask[use_pin] = 1'b1;
		set_mask = set_mask & pin_valid;
	end
	// ======================================================
	// Select word: hardware set wins over a software clear
	always_comb
	begin
		select_next = select_reg;
		if (wr_en && paddr == `APS_SELECT_OFFSET)
			select_next = merge16(select_reg, pwdata, pstrb);
		if (variant == APS_VAR_PIN)
			select_next = (select_next | set_mask) & pin_valid;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			select_reg <= `APS_SELECT_RESET;
		else
			select_reg <= select_next;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			config_reg <= `APS_CONFIG_RESET;
		else if (wr_en && paddr == `APS_CONFIG_OFFSET && pstrb[0])
			config_reg <= pwdata[2:0];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			refcfg_reg <= `APS_REFCFG_RESET;
		else if (wr_en && paddr == `APS_REFCFG_OFFSET && pstrb[0])
			refcfg_reg <= pwdata[3:0];
	end
	// ======================================================
	// Sequential decode
	aps_seq_decode u_seq (
		.count(select_reg[3:0]),
		.large_part(large_part),
		.chan_mask(seq_mask)
	);
	// Lower channel gate: a gap cuts every higher channel off
	function automatic logic [15:0] seq_gate(input logic [15:0] m,
		input logic [15:0] cap, input logic [15:0] inp);
		logic ok;
		ok = 1'b1;
		seq_gate = 16'h0000;
		for (int i = 0; i < 16; i++)
		begin
			if (m[i])
			begin
				ok = ok & cap[i] & inp[i];
				seq_gate[i] = ok;
			end
		end
	endfunction
	// ======================================================
	// Buffer disconnect
	always_comb
	begin
		case (variant)
		APS_VAR_SEQ:
			mask_eff = seq_gate(seq_mask, pin_analog_cap,
				pin_is_input);
		APS_VAR_MASK:
			mask_eff = {3'h0, select_reg[12:0]};
		APS_VAR_PIN:
			mask_eff = select_reg;
		default:
			mask_eff = 16'h0000;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dig_buf_off <= '0;
		else
			dig_buf_off <= mask_eff[PINS-1:0];
	end
	// ======================================================
	// References
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			refp_sel <= APS_REFP_SUPPLY;
			refn_sel <= APS_REFN_GROUND;
			refp_chan <= 4'h0;
			refn_chan <= 4'h0;
		end
		else if (variant == APS_VAR_PIN)
		begin
			refp_sel <= aps_refp_type'(refcfg_reg[1:0]);
			refn_sel <= aps_refn_type'(refcfg_reg[2]);
			refp_chan <= 4'h0;
			refn_chan <= 4'h0;
		end
		else
		begin
			refp_sel <= select_reg[`APS_REFP_BIT] ? APS_REFP_PIN
				: APS_REFP_SUPPLY;
			refn_sel <= (select_reg[`APS_REFN_BIT]
				&& !(variant == APS_VAR_MASK && small_part))
				? APS_REFN_PIN : APS_REFN_GROUND;
			refp_chan <= (variant == APS_VAR_MASK && small_part)
				? 4'(`APS_SMALL_REFP_CH) : 4'(`APS_SEQ_REFP_CH);
			refn_chan <= 4'(`APS_SEQ_REFN_CH);
		end
	end
	// ======================================================
	// Read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (rd_hit)
		begin
			case (paddr)
			`APS_SELECT_OFFSET: prdata <= {16'h0000, select_reg};
			`APS_CONFIG_OFFSET: prdata <= {29'h0, config_reg};
			`APS_STATUS_OFFSET: prdata <= {16'h0000, mask_eff};
			`APS_REFCFG_OFFSET: prdata <= {28'h0, refcfg_reg};
			default: prdata <= 32'h00000000;
			endcase
		end
	end
	// ======================================================
	// Checks
	AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
		(use_valid && variant == APS_VAR_PIN && set_mask != 16'h0000)
		|=> ((select_reg & $past(set_mask)) == $past(set_mask)))
		else $error("automatic pin set lost");
	AST_DEFAULT_REF: assert property (@(posedge pclk) disable iff (!presetn)
		(variant != APS_VAR_PIN && !select_reg[`APS_REFP_BIT]
		&& $stable(variant)) |=> refp_sel == APS_REFP_SUPPLY)
		else $error("positive reference not supply");
	AST_SEQ_GAP: assert property (@(posedge pclk) disable iff (!presetn)
		(variant == APS_VAR_SEQ && !mask_eff[0]) |-> mask_eff == 16'h0)
		else $error("sequential channel enabled above a gap");
	AST_BIT13: assert property (@(posedge pclk) disable iff (!presetn)
		variant == APS_VAR_MASK |-> !mask_eff[13])
		else $error("unused bit 13 drives a buffer");
	AST_WRITE_BACK: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `APS_SELECT_OFFSET && pstrb == 4'hf
		&& variant != APS_VAR_PIN) |=> select_reg == $past(pwdata[15:0]))
		else $error("select word write not stored");
	AST_SMALL_PIN: assert property (@(posedge pclk) disable iff (!presetn)
		(variant == APS_VAR_PIN && small_part) |=> (select_reg & 16'hffe9)
		== 16'h0)
		else $error("absent small-part pin bit set");
	AST_REFN: assert property (@(posedge pclk) disable iff (!presetn)
		(variant == APS_VAR_SEQ && select_reg[`APS_REFN_BIT]
		&& $stable(variant)) |=> refn_sel == APS_REFN_PIN
		&& refn_chan == 4'h2)
		else $error("negative reference not channel 2");
	AST_BUF: assert property (@(posedge pclk) disable iff (!presetn)
		variant == APS_VAR_MASK ##1 $stable(variant)
		|-> dig_buf_off == $past(mask_eff[PINS-1:0]))
		else $error("buffer disconnect does not follow mask");
	// ======================================================
	// Multi-step checks
	// Per-pin variant held for two edges
	sequence s_pin_stable;
		variant == APS_VAR_PIN ##1 $stable(variant);
	endsequence
	// Full software clear of the per-pin word with no hardware use
	sequence s_pin_clear;
		wr_en && paddr == `APS_SELECT_OFFSET && pstrb[1:0] == 2'h3
		&& pwdata[15:0] == 16'h0000 && variant == APS_VAR_PIN
		&& !use_valid;
	endsequence
	AST_SW_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		s_pin_clear |=> select_reg == 16'h0000)
		else $error("software clear of pin bits lost");
	// References follow only the separate setting in this variant
	AST_PIN_REFS: assert property (@(posedge pclk) disable iff (!presetn)
		s_pin_stable |-> refp_sel == aps_refp_type'($past(refcfg_reg[1:0]))
		&& refn_sel == aps_refn_type'($past(refcfg_reg[2])))
		else $error("per-pin reference not from setting");
	AST_MASK_REFP: assert property (@(posedge pclk) disable iff (!presetn)
		(variant == APS_VAR_MASK && select_reg[`APS_REFP_BIT]
		&& $stable(variant)) |=> refp_sel == APS_REFP_PIN
		&& refp_chan == ($past(small_part) ? 4'h1 : 4'h3))
		else $error("mask positive reference channel wrong");
	AST_SEQ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		(variant == APS_VAR_SEQ && select_reg[3:0] == 4'h0)
		|-> mask_eff == 16'h0000)
		else $error("zero count enables a channel");
	// Gap channels below each part's extra block (4-7 small, 4 large) never turn analogue
	AST_SMALL_GAP: assert property (@(posedge pclk) disable iff (!presetn)
		(variant == APS_VAR_SEQ && small_part)
		|-> mask_eff[7:4] == 4'h0)
		else $error("absent small-part channel enabled");
	AST_LARGE_GAP: assert property (@(posedge pclk) disable iff (!presetn)
		(variant == APS_VAR_SEQ && large_part) |-> !mask_eff[4])
		else $error("absent large-part channel enabled");
endmodule // aps_select
`default_nettype wire

// ### src/aps_seq_decode.sv
// Purpose: Channel count to channel mask decode for the sequential variant.
// Assumes: Count fits in the low four bits of the select word.
// Notes:   Combinational only.
`timescale 1ns/100ps
`default_nettype none
`include "aps_regs.svh"
module aps_seq_decode
	import aps_pkg::*;
(
	// Count in
	input wire logic [3:0] count,
	input wire logic large_part,
	// Channel mask out
	output logic [15:0] chan_mask
);
	// ======================================================
	// Decode
	always_comb
	begin
		chan_mask = 16'h0000;
		for (int i = 0; i < `APS_SEQ_BASE_CH; i++)
		begin
			if (count > i[3:0])
				chan_mask[i] = 1'b1;
		end
		for (int k = 0; k < 8; k++)
		begin
			if (count > k[3:0] + 4'h4)
			begin
				if (large_part)
					chan_mask[k + 5] = 1'b1;
				else if (k < 5)
					chan_mask[k + 8] = 1'b1;
			end
		end
	end
endmodule // aps_seq_decode
`default_nettype wire

// ### tb/aps_select_tb.sv
// Purpose: Self-checking bench for the analog pin select block.
// Assumes: Zero-wait APB slave; outputs follow one edge after access.
// Notes: Only mismatches and the verdict are printed.
`timescale 1ns/100ps
`default_nettype none
`include "aps_regs.svh"
module aps_select_tb
	import aps_pkg::*;
;
	// ==========================================================
	// Stimulus and design outputs
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, use_valid = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf, use_pin = 4'h0, refp_chan, refn_chan;
	logic [15:0] cap = 16'hffff, inp = 16'hffff, dig_buf_off;
	logic pready, pslverr, err;
	aps_refp_type refp_sel;
	aps_refn_type refn_sel;
	int failures = 0, comparisons = 0, c;
	always #2 pclk = ~pclk;
	aps_select u_aps_select (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_analog_cap(cap), .pin_is_input(inp), .use_valid(use_valid),
		.use_pin(use_pin), .dig_buf_off(dig_buf_off), .refp_sel(refp_sel),
		.refn_sel(refn_sel), .refp_chan(refp_chan), .refn_chan(refn_chan));
	// ==========================================================
	// Bus cycles and compare
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		// Answer is taken at the edge that sees pready high
		rd = prdata;
		err = pslverr;
		if (n >= 50) failures++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle();
		@(posedge pclk);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		settle();
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_refs(input logic [31:0] p, input logic [31:0] pc,
		input logic [31:0] n, input logic [31:0] nc);
		chk("refp_sel", p, 32'(refp_sel));
		chk("refn_sel", n, 32'(refn_sel));
		if (p == 1) chk("refp_chan", pc, 32'(refp_chan));
		if (n == 1) chk("refn_chan", nc, 32'(refn_chan));
	endtask
	// Lower four channels first, then the part's extra block in order
	function automatic logic [15:0] seq_exp(input int n, input bit lg);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < n; i++)
			m[i < 4 ? i : (lg ? i + 1 : i + 4)] = 1'b1;
		return m;
	endfunction
	task automatic stop_test();
		if (failures == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// Watchdog sized well beyond the few hundred cycles used
	initial
	begin
		#40000;
		failures++;
		stop_test();
	end
	// ==========================================================
	// Tests
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk("dig_buf_off", 32'h0, {16'h0, dig_buf_off});
		chk_refs(0, 0, 0, 0);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		wr(`APS_CONFIG_OFFSET, 32'h4);
		for (c = 0; c <= 12; c++)
		begin
			wr(`APS_SELECT_OFFSET, c);
			chk("seq large", seq_exp(c, 1), dig_buf_off);
		end
		wr(`APS_CONFIG_OFFSET, 32'h0);
		for (c = 0; c <= 9; c++)
		begin
			wr(`APS_SELECT_OFFSET, c);
			chk("seq small", seq_exp(c, 0), dig_buf_off);
		end
		// A gap in capability or direction stops every higher channel
		cap <= 16'hfffd;
		wr(`APS_SELECT_OFFSET, 32'h4);
		chk("seq cap", 32'h1, dig_buf_off);
		cap <= 16'hffff;
		inp <= 16'hfff7;
		wr(`APS_SELECT_OFFSET, 32'h4);
		chk("seq input", 32'h7, dig_buf_off);
		inp <= 16'hffff;
		wr(`APS_SELECT_OFFSET, 32'hc004);
		chk_refs(1, 3, 1, 2);
		apb(1'b0, `APS_SELECT_OFFSET, 32'h0);
		chk("select word", 32'hc004, rd);
		wr(`APS_CONFIG_OFFSET, 32'h5);
		wr(`APS_SELECT_OFFSET, 32'hffff);
		chk("mask large", 32'h1fff, dig_buf_off);
		chk_refs(1, 3, 1, 2);
		wr(`APS_SELECT_OFFSET, 32'h0005);
		chk("mask clear", 32'h5, dig_buf_off);
		chk_refs(0, 0, 0, 0);
		wr(`APS_CONFIG_OFFSET, 32'h1);
		wr(`APS_SELECT_OFFSET, 32'hc002);
		chk("mask small", 32'h2, dig_buf_off);
		chk_refs(1, 1, 0, 0);
		wr(`APS_CONFIG_OFFSET, 32'h7);
		wr(`APS_SELECT_OFFSET, 32'hc000);
		chk_refs(0, 0, 0, 0);
		@(posedge pclk);
		use_valid <= 1'b1;
		use_pin <= 4'h9;
		@(posedge pclk);
		use_valid <= 1'b0;
		settle();
		apb(1'b0, `APS_SELECT_OFFSET, 32'h0);
		chk("auto set", 32'hc200, rd);
		wr(`APS_SELECT_OFFSET, 32'h0000);
		chk("sw clear", 32'h0, dig_buf_off);
		wr(`APS_REFCFG_OFFSET, 32'h5);
		chk_refs(1, 0, 1, 0);
		wr(`APS_CONFIG_OFFSET, 32'h3);
		wr(`APS_SELECT_OFFSET, 32'hffff);
		chk("pin small", 32'h0016, dig_buf_off);
		apb(1'b0, `APS_STATUS_OFFSET, 32'h0);
		chk("status", 32'h0016, rd);
		chk("pready", 32'h1, {31'h0, pready});
		apb(1'b0, `APS_CONFIG_OFFSET, 32'h0);
		chk("config", 32'h3, rd);
		// A write to a hole must leave the select word alone
		wr(12'h010, 32'h0000ffff);
		chk("unmapped werr", 32'h1, {31'h0, err});
		apb(1'b0, `APS_SELECT_OFFSET, 32'h0);
		chk("unmapped write", 32'h0016, rd);
		wr(`APS_REFCFG_OFFSET, 32'h2);
		chk_refs(2, 0, 0, 0);
		stop_test();
	end
endmodule // aps_select_tb
`default_nettype wire
